// >>> rtl/power_ctl_map.svh
// register indices, field positions, reset values and timing figures of the power controller
`ifndef POWER_CTL_MAP_SVH
`define POWER_CTL_MAP_SVH

// register indices; byte address is four times the index
`define PSC_IDX_ACTIVATE 8'h30
`define PSC_IDX_CTL1 8'h40
`define PSC_IDX_CTL2 8'h41
`define PSC_IDX_STATUS 8'h42

// activation register fields
`define PSC_ACT_EN 0

// power control register 1 fields
`define PSC_CTL1_DELAY_LONG 1
`define PSC_CTL1_POR_LEVEL 2
`define PSC_CTL1_POR_CLEAR 3
`define PSC_CTL1_ACTIVATION_MASK_AFTER_FAILURE 4
`define PSC_CTL1_SW_OFF 5
`define PSC_CTL1_FS_RESET 6
`define PSC_CTL1_PFAIL 7

// power control register 2 fields
`define PSC_CTL2_TM_EN 0
`define PSC_CTL2_RING_MODE 2
`define PSC_CTL2_RING_EN 3
`define PSC_CTL2_RI1_EN 4
`define PSC_CTL2_RI2_EN 5
`define PSC_CTL2_OFF_DELAY 6

// status register fields, all cleared by a read
`define PSC_ST_TMD 0
`define PSC_ST_RING 1
`define PSC_ST_RI1 2
`define PSC_ST_RI2 3
`define PSC_ST_SW_ON 4
`define PSC_ST_SW_OFF 5

// default values loaded after no power
`define PSC_ACT_RST 1'h0
`define PSC_CTL1_RST 8'h00
`define PSC_CTL2_RST 8'h00
`define PSC_ST_RST 6'h00

// timing figures in their own units and the clock rate
`define PSC_CLK_HZ 64'd100000000
`define PSC_RECOVERY_S 64'd1
`define PSC_DEBOUNCE_MS 64'd14
`define PSC_FS_SHORT_S 64'd4
`define PSC_FS_LONG_S 64'd20

// cycle counts derived from the figures
`define PSC_RECOVERY_CYC (`PSC_CLK_HZ * `PSC_RECOVERY_S)
`define PSC_DEBOUNCE_CYC ((`PSC_CLK_HZ * `PSC_DEBOUNCE_MS + 64'd999) / 64'd1000)
`define PSC_FS_SHORT_CYC (`PSC_CLK_HZ * `PSC_FS_SHORT_S)
`define PSC_FS_LONG_CYC (`PSC_CLK_HZ * `PSC_FS_LONG_S)

`endif

// >>> rtl/power_ctl_pkg.sv
// types shared by the power controller
`default_nettype none
package power_ctl_pkg;
	// classified system power state
	typedef enum logic [1:0] {
		ps_no_power,
		ps_on,
		ps_off,
		ps_failure
	} power_state_t;

	// supply presence indications
	typedef struct packed {
		logic main_present;
		logic standby_present;
		logic battery_present;
		logic sys_below_bat;
	} supply_t;

	// wake and switch inputs, active-low pins keep their pin level
	typedef struct packed {
		logic switch_n;
		logic ring_n;
		logic ring_train;
		logic serial_ring_indicator_1_n;
		logic serial_ring_indicator_2_n;
		logic time_match;
	} wake_t;
endpackage : power_ctl_pkg
`default_nettype wire

// >>> rtl/system_power_state_control.sv
// always-on power supply controller with set-reset supply enable and wishbone registers
//
// What this block does
// - main present is on; standby only is off
// - battery without standby means power failure
// - defaults loaded only after no power
// - system supply near battery enters failure
// - wait one second after failure recovery
// - supply enable is a set-reset flip-flop
// - flip-flop holds its value through failure
// - enabled time match activates supply
// - switch-on event activates supply
// - ring edge or train activates when enabled
// - enabled serial ring falling edge activates
// - switch-off without delay deactivates at once
// - fail-safe terminal count deactivates supply
// - software off command deactivates supply
// - flip-flop one means supply inactive
// - registers locked while activation bit clear
// - switch-off raises power-off request
// - failure masks wake inputs other than time match unless mask bit set
// - failure saves state and forces inactive
// - after one second restore unless masked
// - time match in failure remembered
// - mask plus failure flag: switch only
// - switch debounced 14 to 16 ms
// - off-delay bit starts fail-safe countdown
// - delay select: 4 or 20 seconds
// - fail-safe reset command stops timer
`include "power_ctl_map.svh"
`default_nettype none
module system_power_state_control #(
	parameter int unsigned RECOVERY_CYCLES = 32'(`PSC_RECOVERY_CYC),
	parameter int unsigned DEBOUNCE_CYCLES = 32'(`PSC_DEBOUNCE_CYC),
	parameter int unsigned FS_SHORT_CYCLES = 32'(`PSC_FS_SHORT_CYC),
	parameter int unsigned FS_LONG_CYCLES = 32'(`PSC_FS_LONG_CYC)
) (
	// clock and first-power reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// supplies and wake sources
	input wire power_ctl_pkg::supply_t supply_i,
	input wire power_ctl_pkg::wake_t wake_i,
	// power supply side
	output logic supply_enable_out_n_o,
	output logic power_off_req_n_o,
	output var power_ctl_pkg::power_state_t power_state_o
);
	// supply synchroniser: first stage read by the second only
	power_ctl_pkg::supply_t sup_meta;
	power_ctl_pkg::supply_t sup;
	always_ff @(posedge clk_i) begin
		sup_meta <= supply_i;
		sup <= sup_meta;
	end

	// power state classification
	wire no_pwr = !sup.battery_present && !sup.standby_present;
	wire fail_cond = (!sup.standby_present && sup.battery_present) || sup.sys_below_bat;
	power_ctl_pkg::power_state_t state;
	power_ctl_pkg::power_state_t next_state;
	assign next_state = no_pwr ? power_ctl_pkg::ps_no_power :
		fail_cond ? power_ctl_pkg::ps_failure :
		sup.main_present ? power_ctl_pkg::ps_on : power_ctl_pkg::ps_off;
	wire in_fail = (state == power_ctl_pkg::ps_failure);
	wire leave_fail = in_fail && (next_state == power_ctl_pkg::ps_on ||
		next_state == power_ctl_pkg::ps_off);
	wire enter_fail = !in_fail && (next_state == power_ctl_pkg::ps_failure);
	// init covers first power and any return from no power, never a system reset
	wire init = rst_i || no_pwr;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= power_ctl_pkg::ps_no_power;
		end else begin
			state <= next_state;
		end
	end

	// register storage
	logic act;
	logic delay_long;
	logic por_level;
	logic activation_mask_after_failure;
	logic pfail;
	logic tm_en;
	logic ring_mode;
	logic ring_en;
	logic ri1_en;
	logic ri2_en;
	logic off_delay;
	logic [5:0] status;
	localparam logic [7:0] CTL1_DEF = `PSC_CTL1_RST; // default images, indexed per field
	localparam logic [7:0] CTL2_DEF = `PSC_CTL2_RST;

	// bus decode; registers other than activation answer zero while locked
	wire [7:0] idx = wb_adr_i[9:2];
	wire in_range = (wb_adr_i[11:10] == 2'h0);
	wire req = wb_cyc_i && wb_stb_i;
	wire hit_act = in_range && (idx == `PSC_IDX_ACTIVATE);
	wire hit_ctl1 = in_range && (idx == `PSC_IDX_CTL1) && act;
	wire hit_ctl2 = in_range && (idx == `PSC_IDX_CTL2) && act;
	wire hit_st = in_range && (idx == `PSC_IDX_STATUS) && act;
	wire wr_fire = req && wb_ack_o && wb_we_i && wb_sel_i[0];
	wire rd_fire = req && !wb_ack_o && !wb_we_i; // status clears as the word is captured
	wire wr_act = wr_fire && hit_act;
	wire wr_ctl1 = wr_fire && hit_ctl1;
	wire wr_ctl2 = wr_fire && hit_ctl2;
	wire rd_st = rd_fire && hit_st;
	wire sw_off_cmd = wr_ctl1 && wb_dat_i[`PSC_CTL1_SW_OFF];
	wire fs_reset_cmd = wr_ctl1 && wb_dat_i[`PSC_CTL1_FS_RESET];
	wire por_clear_cmd = wr_ctl1 && wb_dat_i[`PSC_CTL1_POR_CLEAR];
	wire pfail_clear = wr_ctl1 && wb_dat_i[`PSC_CTL1_PFAIL];

	// read mux; command bits read as zero
	wire [7:0] rd_ctl1 = {pfail, 2'h0, activation_mask_after_failure, 1'h0, por_level, delay_long, 1'h0};
	wire [7:0] rd_ctl2 = {1'h0, off_delay, ri2_en, ri1_en, ring_en, ring_mode, 1'h0, tm_en};
	wire [7:0] rdata = hit_act ? {7'h00, act} : hit_ctl1 ? rd_ctl1 :
		hit_ctl2 ? rd_ctl2 : hit_st ? {2'h0, status} : 8'h00;

	// classic wishbone answer: ack one cycle after request, dropped the next
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req && !wb_ack_o;
			wb_dat_o <= (req && !wb_ack_o) ? {24'h000000, rdata} : wb_dat_o;
		end
	end

	// configuration registers, defaults loaded at first-power reset and during no power, bus writes otherwise
	always_ff @(posedge clk_i) begin
		if (init) begin
			act <= `PSC_ACT_RST;
			{activation_mask_after_failure, por_level, delay_long} <= {CTL1_DEF[`PSC_CTL1_ACTIVATION_MASK_AFTER_FAILURE],
				CTL1_DEF[`PSC_CTL1_POR_LEVEL], CTL1_DEF[`PSC_CTL1_DELAY_LONG]};
			{off_delay, ri2_en, ri1_en, ring_en, ring_mode, tm_en} <= {
				CTL2_DEF[`PSC_CTL2_OFF_DELAY], CTL2_DEF[`PSC_CTL2_RI2_EN],
				CTL2_DEF[`PSC_CTL2_RI1_EN], CTL2_DEF[`PSC_CTL2_RING_EN],
				CTL2_DEF[`PSC_CTL2_RING_MODE], CTL2_DEF[`PSC_CTL2_TM_EN]};
		end else begin
			act <= wr_act ? wb_dat_i[`PSC_ACT_EN] : act;
			if (wr_ctl1) begin
				activation_mask_after_failure <= wb_dat_i[`PSC_CTL1_ACTIVATION_MASK_AFTER_FAILURE];
				por_level <= wb_dat_i[`PSC_CTL1_POR_LEVEL];
				delay_long <= wb_dat_i[`PSC_CTL1_DELAY_LONG];
			end
			if (wr_ctl2) begin
				off_delay <= wb_dat_i[`PSC_CTL2_OFF_DELAY];
				ri2_en <= wb_dat_i[`PSC_CTL2_RI2_EN];
				ri1_en <= wb_dat_i[`PSC_CTL2_RI1_EN];
				ring_en <= wb_dat_i[`PSC_CTL2_RING_EN];
				ring_mode <= wb_dat_i[`PSC_CTL2_RING_MODE];
				tm_en <= wb_dat_i[`PSC_CTL2_TM_EN];
			end
		end
	end

	// power-fail flag: set on entry wins over a clearing write
	always_ff @(posedge clk_i) begin
		if (init) begin
			pfail <= CTL1_DEF[`PSC_CTL1_PFAIL];
		end else begin
			pfail <= enter_fail || (pfail && !pfail_clear);
		end
	end

	// one-second recovery timer, started when standby returns
	logic recovering;
	logic [31:0] rec_cnt;
	wire rec_done = recovering && (rec_cnt == 32'h0000_0001);
	always_ff @(posedge clk_i) begin
		if (init) begin
			recovering <= 1'b0;
			rec_cnt <= 32'h0000_0000;
		end else if (leave_fail) begin
			recovering <= 1'b1;
			rec_cnt <= RECOVERY_CYCLES;
		end else if (in_fail || rec_done) begin
			recovering <= 1'b0;
			rec_cnt <= 32'h0000_0000;
		end else if (recovering) begin
			rec_cnt <= rec_cnt - 32'h0000_0001;
		end
	end

	// switch, ring and serial ring inputs held high and ring train held low through failure and the recovery second while activation_mask_after_failure is clear
	wire mask_inputs = (in_fail || recovering) && !activation_mask_after_failure;
	wire sw_raw = mask_inputs ? 1'b1 : wake_i.switch_n;
	wire ring_m = mask_inputs ? 1'b1 : wake_i.ring_n;
	wire ri1_m = mask_inputs ? 1'b1 : wake_i.serial_ring_indicator_1_n;
	wire ri2_m = mask_inputs ? 1'b1 : wake_i.serial_ring_indicator_2_n;
	wire train_m = !mask_inputs && wake_i.ring_train;

	// switch debounce: a new level needs a full quiet interval
	logic sw_db;
	logic sw_db_prev;
	logic [31:0] db_cnt;
	always_ff @(posedge clk_i) begin
		if (init) begin
			sw_db <= 1'b1;
			sw_db_prev <= 1'b1;
			db_cnt <= 32'h0000_0000;
		end else begin
			sw_db_prev <= sw_db;
			if (sw_raw == sw_db) begin
				db_cnt <= 32'h0000_0000;
			end else if (db_cnt == DEBOUNCE_CYCLES - 32'h0000_0001) begin
				sw_db <= sw_raw;
				db_cnt <= 32'h0000_0000;
			end else begin
				db_cnt <= db_cnt + 32'h0000_0001;
			end
		end
	end

	// edge detection on ring, serial ring and time match inputs; ring train is used as a level
	logic ring_prev;
	logic ri1_prev;
	logic ri2_prev;
	logic tm_prev;
	always_ff @(posedge clk_i) begin
		if (init) begin
			{ring_prev, ri1_prev, ri2_prev, tm_prev} <= 4'hE;
		end else begin
			{ring_prev, ri1_prev, ri2_prev, tm_prev} <= {ring_m, ri1_m, ri2_m, wake_i.time_match};
		end
	end

	// event terms
	wire sw_fall = sw_db_prev && !sw_db;
	wire sw_on_ev = sw_fall && !sup.main_present;
	wire sw_off_ev = sw_fall && sup.main_present;
	wire ring_fall = ring_prev && !ring_m;
	wire ri1_fall = ri1_prev && !ri1_m;
	wire ri2_fall = ri2_prev && !ri2_m;
	wire tm_rise = wake_i.time_match && !tm_prev;
	wire ring_ev = ring_en && (ring_mode ? train_m : ring_fall);
	wire ri_ev = (ri1_en && ri1_fall) || (ri2_en && ri2_fall);
	wire tm_ev = tm_en && tm_rise;
	wire only_switch = activation_mask_after_failure && pfail;
	wire held = in_fail || recovering;
	wire set_cond = !held && (sw_on_ev || (!only_switch && (tm_ev || ring_ev || ri_ev)));

	// fail-safe timer; further switch-off events are ignored while it runs
	logic fs_run;
	logic [31:0] fs_cnt;
	wire fs_expire = fs_run && (fs_cnt == 32'h0000_0000);
	always_ff @(posedge clk_i) begin
		if (init || fs_reset_cmd || !sup.main_present || fs_expire) begin
			fs_run <= 1'b0;
			fs_cnt <= 32'h0000_0000;
		end else if (sw_off_ev && off_delay && !fs_run) begin
			fs_run <= 1'b1;
			fs_cnt <= (delay_long ? FS_LONG_CYCLES : FS_SHORT_CYCLES) - 32'h0000_0001;
		end else if (fs_run) begin
			fs_cnt <= fs_cnt - 32'h0000_0001;
		end
	end

	// supply-enable flip-flop, one means inactive; deactivation wins
	logic onff;
	logic saved;
	logic tm_pending;
	wire reset_cond = (sw_off_ev && !off_delay) || fs_expire || sw_off_cmd;
	always_ff @(posedge clk_i) begin
		if (init) begin
			onff <= 1'b1;
		end else if (reset_cond) begin
			onff <= 1'b1;
		end else if (rec_done) begin
			onff <= activation_mask_after_failure ? 1'b1 : (saved && !tm_pending);
		end else if (set_cond) begin
			onff <= 1'b0;
		end
	end

	// failure bookkeeping; onff itself is left alone during failure
	always_ff @(posedge clk_i) begin
		if (init) begin
			saved <= 1'b1;
			tm_pending <= 1'b0;
		end else begin
			saved <= enter_fail ? onff : saved;
			tm_pending <= held && (tm_pending || (tm_ev && !activation_mask_after_failure));
		end
	end

	// registered outputs; failure and recovery force supply off
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			supply_enable_out_n_o <= 1'b1;
			power_state_o <= power_ctl_pkg::ps_no_power;
		end else begin
			supply_enable_out_n_o <= onff || held;
			power_state_o <= next_state;
		end
	end

	// power-off request: pulse in edge mode, held until cleared in level mode
	always_ff @(posedge clk_i) begin
		if (init) begin
			power_off_req_n_o <= 1'b1;
		end else if (sw_off_ev) begin
			power_off_req_n_o <= 1'b0;
		end else if (!por_level || por_clear_cmd) begin
			power_off_req_n_o <= 1'b1;
		end
	end

	// sticky status, event wins over the clearing read
	wire [5:0] st_set = {sw_off_ev, sw_on_ev, ri2_fall, ri1_fall,
		ring_mode ? train_m : ring_fall, tm_rise};
	always_ff @(posedge clk_i) begin
		if (init) begin
			status <= `PSC_ST_RST;
		end else begin
			status <= (status & {6{!rd_st}}) | st_set;
		end
	end

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_fail_state;
		(!sup.standby_present && sup.battery_present) |=> state == power_ctl_pkg::ps_failure;
	endproperty
	a_fail_state: assert property (p_fail_state) else $error("failure state missed");
	property p_on_state;
		(sup.main_present && sup.standby_present && !sup.sys_below_bat) |=>
			state == power_ctl_pkg::ps_on && power_state_o == power_ctl_pkg::ps_on;
	endproperty
	a_on_state: assert property (p_on_state) else $error("power on not classified");
	property p_below_bat;
		(sup.sys_below_bat && !no_pwr) |=> in_fail ##1 supply_enable_out_n_o;
	endproperty
	a_below_bat: assert property (p_below_bat) else $error("low supply not failure");
	property p_fail_off;
		in_fail |=> supply_enable_out_n_o;
	endproperty
	a_fail_off: assert property (p_fail_off) else $error("supply on during failure");
	property p_sw_off;
		(sw_off_ev && !off_delay) |-> ##2 supply_enable_out_n_o;
	endproperty
	a_sw_off: assert property (p_sw_off) else $error("switch-off did not cut supply");
	property p_soc;
		sw_off_cmd |=> onff ##1 supply_enable_out_n_o;
	endproperty
	a_soc: assert property (p_soc) else $error("software off ignored");
	property p_por;
		sw_off_ev |=> !power_off_req_n_o;
	endproperty
	a_por: assert property (p_por) else $error("no power-off request");
	property p_defaults;
		no_pwr |=> !act && !activation_mask_after_failure && !off_delay && !pfail && status == 6'h00;
	endproperty
	a_defaults: assert property (p_defaults) else $error("defaults not loaded");
	property p_sw_on;
		(sw_on_ev && !reset_cond && !held && !rec_done) |=> !onff;
	endproperty
	a_sw_on: assert property (p_sw_on) else $error("switch-on did not set");
	property p_only_switch;
		(onff && only_switch && !sw_on_ev && !rec_done) |=> onff;
	endproperty
	a_only_switch: assert property (p_only_switch) else $error("masked wake got through");
	property p_fs_expire;
		fs_expire |=> onff && !fs_run;
	endproperty
	a_fs_expire: assert property (p_fs_expire) else $error("fail-safe did not cut");
	property p_mask;
		mask_inputs |-> sw_raw && ring_m && ri1_m && ri2_m && !train_m;
	endproperty
	a_mask: assert property (p_mask) else $error("wake inputs not masked");
	property p_ack;
		(req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("bus ack timing wrong");

	c_sw_on: cover property (sw_on_ev ##1 !onff);
	c_fs_expire: cover property (fs_expire);
	c_recovery: cover property (rec_done && !activation_mask_after_failure);
	c_por_level: cover property (sw_off_ev && por_level);
endmodule : system_power_state_control
`default_nettype wire

// >>> verif/psu_model.sv
// behavioural host power supply that answers the supply enable output
`default_nettype none
module psu_model (
	// clock
	input wire logic clk_i,
	// mains and battery presence set by the bench
	input wire logic ac_i,
	input wire logic bat_i,
	// supply enable from the controller, active low
	input wire logic supply_enable_out_n_i,
	// presence indications back to the controller
	output wire power_ctl_pkg::supply_t supply_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic main_on = 1'b0;

	// main rail ramps one cycle after enable, but collapses at once with mains
	always @(posedge clk_i) begin
		main_on <= ac_i && !supply_enable_out_n_i;
	end

	// standby follows mains; the comparator trips as soon as mains goes
	assign supply_o.main_present = main_on && ac_i;
	assign supply_o.standby_present = ac_i;
	assign supply_o.battery_present = bat_i;
	assign supply_o.sys_below_bat = !ac_i;
endmodule : psu_model
`default_nettype wire

// >>> verif/tb_system_power_state_control.sv
// self-checking bench for the power supply controller
`default_nettype none
module tb_system_power_state_control;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int REC = 50;
	localparam int DEB = 8;
	localparam int FSS = 40;
	localparam int FSL = 100;
	localparam int LIMIT = 20000;
	// bench signals
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [11:0] wb_adr_i = 12'h000;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic ac = 1'b1;
	logic bat = 1'b1;
	power_ctl_pkg::supply_t supply;
	power_ctl_pkg::wake_t wake_i = 6'h36;
	logic en_n;
	logic por_n;
	logic en_prev = 1'b1;
	power_ctl_pkg::power_state_t power_state;
	int failures = 0;
	int check_count = 0;
	int cycles = 0;
	int seed = 35025;
	int por_at = 0;
	int en_hi_at = 0;
	logic [31:0] exp_q[$];
	logic [7:0] ctl2_tab [5] = '{8'h01, 8'h08, 8'h0C, 8'h10, 8'h20};
	logic [5:0] mask_tab [5] = '{6'h01, 6'h10, 6'h08, 6'h04, 6'h02};

	always #5 clk_i = ~clk_i;

	system_power_state_control #(.RECOVERY_CYCLES(REC), .DEBOUNCE_CYCLES(DEB),
		.FS_SHORT_CYCLES(FSS), .FS_LONG_CYCLES(FSL)) DUT (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.supply_i(supply), .wake_i(wake_i), .supply_enable_out_n_o(en_n),
		.power_off_req_n_o(por_n), .power_state_o(power_state));

	psu_model psu (.clk_i(clk_i), .ac_i(ac), .bat_i(bat), .supply_enable_out_n_i(en_n),
		.supply_o(supply));

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one classic cycle; released only at the edge where ack is seen high
	task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] dat);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hF;
		wb_dat_i <= dat;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1) @(posedge clk_i);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb

	task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
		wb(1'b1, adr, dat);
	endtask : wr

	// the expected word is noted first, the monitor compares it at ack
	task automatic rd_chk(input logic [11:0] adr, input logic [31:0] exp);
		exp_q.push_back(exp);
		wb(1'b0, adr, 32'h0);
	endtask : rd_chk

	task automatic wait_en(input logic exp, input int max, output int n);
		n = 0;
		while (en_n !== exp && n < max) begin
			@(negedge clk_i);
			n++;
		end
		@(negedge clk_i);
	endtask : wait_en

	task automatic pulse(input logic [5:0] mask);
		@(posedge clk_i);
		wake_i <= power_ctl_pkg::wake_t'(6'h36 ^ mask);
		repeat (3) @(posedge clk_i);
		wake_i <= power_ctl_pkg::wake_t'(6'h36);
	endtask : pulse

	// held and released well past the debounce interval
	task automatic press();
		@(posedge clk_i);
		wake_i.switch_n <= 1'b0;
		repeat (DEB + 6) @(posedge clk_i);
		wake_i.switch_n <= 1'b1;
		repeat (DEB + 6) @(posedge clk_i);
	endtask : press

	task automatic tm_on(input logic [31:0] ctl2);
		int n;
		wr(12'h104, ctl2);
		pulse(6'h01);
		wait_en(1'b0, 20, n);
		check(32'(en_n), 32'h0);
	endtask : tm_on

	task automatic sw_off(input logic [31:0] ctl1);
		int n;
		wr(12'h100, ctl1 | 32'h20);
		wait_en(1'b1, 10, n);
		check(32'(en_n), 32'h1);
	endtask : sw_off

	// read monitor: the word is taken at the rising edge where ack is seen high
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_cyc_i === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
			check(wb_dat_o, exp_q.pop_front());
	end

	// event timestamps and the hang limit
	always @(negedge clk_i) begin
		cycles++;
		if (por_n === 1'b0 && por_at == 0)
			por_at = cycles;
		if (en_n === 1'b1 && en_prev === 1'b0)
			en_hi_at = cycles;
		en_prev = en_n;
		if (cycles == LIMIT) begin
			failures++;
			complete_run();
		end
	end

	initial begin
		int i;
		int n;
		logic [31:0] r;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(negedge clk_i);
		check(32'(power_state), 32'(power_ctl_pkg::ps_off));
		rd_chk(12'h0C0, 32'h0);
		wr(12'h104, 32'h01);
		rd_chk(12'h104, 32'h0);
		wr(12'h0C0, 32'h1);
		rd_chk(12'h0C0, 32'h1);
		rd_chk(12'h100, 32'h0);
		rd_chk(12'h104, 32'h0);
		rd_chk(12'h108, 32'h0);
		r = $random(seed);
		wr(12'h104, r);
		rd_chk(12'h104, r & 32'h7D);
		wr(12'h3F0, r);
		rd_chk(12'h3F0, 32'h0);
		// switch on, then switch off with no delay
		wr(12'h104, 32'h0);
		por_at = 0;
		press();
		check(32'(en_n), 32'h0);
		check(32'(power_state), 32'(power_ctl_pkg::ps_on));
		check(32'(por_at), 32'h0);
		rd_chk(12'h108, 32'h10);
		wr(12'h100, 32'h04);
		press();
		check(32'(en_n), 32'h1);
		check(32'(por_at != 0), 32'h1);
		check(32'(por_n), 32'h0);
		wr(12'h100, 32'h08);
		@(negedge clk_i);
		check(32'(por_n), 32'h1);
		check(32'(en_hi_at + 1 >= por_at && en_hi_at <= por_at + 2), 32'h1);
		check(32'(power_state), 32'(power_ctl_pkg::ps_off));
		rd_chk(12'h108, 32'h20);
		// every wake source with its own enable
		for (i = 0; i < 5; i++) begin
			wr(12'h104, 32'(ctl2_tab[i]));
			pulse(mask_tab[i]);
			wait_en(1'b0, 20, n);
			check(32'(en_n), 32'h0);
			sw_off(32'h0);
		end
		// a source whose enable is clear leaves the supply off
		wr(12'h104, 32'h0);
		i = $unsigned($random(seed)) % 5;
		pulse(mask_tab[i]);
		wait_en(1'b0, 20, n);
		check(32'(en_n), 32'h1);
		// delayed switch off, short and long fail-safe
		for (i = 0; i < 2; i++) begin
			wr(12'h100, 32'(i * 2));
			tm_on(32'h41);
			por_at = 0;
			press();
			wait_en(1'b1, FSL + 20, n);
			n = en_hi_at - por_at;
			r = (i == 1) ? FSL : FSS;
			check(32'(n >= r - 3 && n <= r + 6), 32'h1);
		end
		// the fail-safe reset command cancels the countdown
		tm_on(32'h41);
		press();
		wr(12'h100, 32'h42);
		wait_en(1'b1, FSL + 20, n);
		check(32'(en_n), 32'h0);
		sw_off(32'h02);
		// failure: restore, masked restore, time match remembered
		for (i = 0; i < 3; i++) begin
			wr(12'h100, (i == 1) ? 32'h10 : 32'h00);
			if (i < 2)
				tm_on(32'h01);
			@(posedge clk_i);
			ac <= 1'b0;
			repeat (6) @(posedge clk_i);
			check(32'(power_state), 32'(power_ctl_pkg::ps_failure));
			check(32'(en_n), 32'h1);
			if (i == 2)
				pulse(6'h01);
			@(posedge clk_i);
			ac <= 1'b1;
			wait_en(1'b0, REC + 20, n);
			if (i == 1)
				check(32'(en_n), 32'h1);
			else
				check(32'(n >= REC && n <= REC + 8), 32'h1);
			if (i == 1) begin
				pulse(6'h01);
				wait_en(1'b0, 20, n);
				check(32'(en_n), 32'h1);
			end
			rd_chk(12'h100, (i == 1) ? 32'h90 : 32'h80);
			wr(12'h100, (i == 1) ? 32'h90 : 32'h80);
			rd_chk(12'h100, (i == 1) ? 32'h10 : 32'h00);
			if (i != 1)
				sw_off(32'h0);
		end
		// losing every supply reloads the defaults
		@(posedge clk_i);
		ac <= 1'b0;
		bat <= 1'b0;
		repeat (4) @(posedge clk_i);
		check(32'(power_state), 32'(power_ctl_pkg::ps_no_power));
		ac <= 1'b1;
		bat <= 1'b1;
		repeat (4) @(posedge clk_i);
		rd_chk(12'h0C0, 32'h0);
		complete_run();
	end
endmodule : tb_system_power_state_control
`default_nettype wire
